// ### src/hpc_cutoff_ctrl.sv
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module hpc_cutoff_ctrl
  import hpc_pkg::*;
#(
  parameter int IGN_CYC = hpc_pkg::OFF_IGNORE_CYC,
  parameter int MS_CYC_P = hpc_pkg::MS_CYC,
  parameter int CUTOFF_CYC = hpc_pkg::CUTOFF_MAX_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Safety pins, high while ON
  input wire logic safety_cutoff_in_a,
  input wire logic safety_cutoff_in_b,
  // Host pins
  input wire logic servo_on_cmd,
  input wire logic main_power_ok,
  // Utility sequencer, same clock
  input wire logic utility_active,
  // Register port
  input wire logic [hpc_pkg::AW-1:0] reg_addr,
  input wire logic [hpc_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [hpc_pkg::DW-1:0] reg_rdata,
  // Drive outputs
  output logic power_stage_en,
  output logic servo_ready,
  output logic brake_release_out,
  output logic dyn_brake_out,
  output logic hard_power_cutoff,
  output logic input_mismatch_alarm,
  output logic utility_lock,
  output logic irq
);
  import hpc_pkg::*;

  typedef struct packed {
    logic [1:0] h1;
    logic [1:0] h2;
    hpc_state_t st;
    logic pwr_hold;
    logic util_lock;
    logic alarm;
    logic [CW-1:0] ms_cnt;
    logic ms_tick;
    logic [7:0] brk_cnt;
    logic [7:0] mm_cnt;
    logic always_set;
    logic dynbrk_set;
    logic [7:0] brk_dly;
    logic [7:0] mm_win;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic [DW-1:0] rdata;
    logic pwr_en;
    logic rdy;
    logic brk_rel;
    logic dyn_brk;
    logic cut;
    logic irq;
  } hpc_ctrl_t;

  hpc_ctrl_t r_reg;
  hpc_ctrl_t r_next;

  logic [1:0] pin_on;
  logic [1:0] f_on;
  logic [1:0] f_sync;
  logic [1:0] f_glitch;
  logic son;
  logic pwr_ok;
  logic both_on;
  logic [INT_W-1:0] ev;

  assign pin_on = {safety_cutoff_in_b, safety_cutoff_in_a};

  // ****************************************
  // Input filters
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      logic [CW-1:0] off_run;

      hpc_off_filter #(
        .IGN_CYC(IGN_CYC),
        .CW(CW)
      ) u_filt (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_on(pin_on[gi]),
        .on_out(f_on[gi]),
        .on_sync(f_sync[gi]),
        .glitch(f_glitch[gi])
      );

      // Consecutive synchronised OFF cycles
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          off_run <= '0;
        end else if (f_sync[gi]) begin
          off_run <= '0;
        end else if (off_run != '1) begin
          off_run <= off_run + 1'b1;
        end
      end

      a_off_pulse_len: assert property (
        @(posedge clk) disable iff (sys_rst)
        $fell(f_on[gi]) |-> (off_run == CW'(IGN_CYC + 1)))
        else $error("OFF recognised at wrong pulse length");
    end
  endgenerate

  // ****************************************
  // Control logic
  // ****************************************
  always_comb begin
    r_next = r_reg;
    ev = '0;
    r_next.h1 = {main_power_ok, servo_on_cmd};
    r_next.h2 = r_reg.h1;
    son = r_reg.h2[0] | r_reg.always_set;
    pwr_ok = r_reg.h2[1];
    both_on = &f_on;

    // Millisecond tick
    r_next.ms_tick = 1'b0;
    if (r_reg.ms_cnt == CW'(MS_CYC_P - 1)) begin
      r_next.ms_cnt = '0;
      r_next.ms_tick = 1'b1;
    end else begin
      r_next.ms_cnt = r_reg.ms_cnt + 1'b1;
    end

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: begin
          r_next.always_set = reg_wdata[CTRL_ALWAYS_BIT];
          r_next.dynbrk_set = reg_wdata[CTRL_DYNBRK_BIT];
          if (reg_wdata[CTRL_ALM_CLR_BIT]) begin
            r_next.alarm = 1'b0;
          end
        end
        ADDR_BRK_DLY: r_next.brk_dly = reg_wdata;
        ADDR_MM_WIN: r_next.mm_win = reg_wdata;
        ADDR_INT_STAT: r_next.int_stat = r_reg.int_stat & ~reg_wdata[INT_W-1:0];
        ADDR_INT_MASK: r_next.int_mask = reg_wdata[INT_W-1:0];
        default: ;
      endcase
    end

    // Channel mismatch window
    if (f_on[0] != f_on[1]) begin
      if (r_reg.mm_cnt >= r_reg.mm_win) begin
        if (!r_reg.alarm) begin
          ev[INT_ALM] = 1'b1;
        end
        r_next.alarm = 1'b1;
      end else if (r_reg.ms_tick) begin
        r_next.mm_cnt = r_reg.mm_cnt + 1'b1;
      end
    end else begin
      r_next.mm_cnt = '0;
    end

    // Utility must be left before release
    if (!utility_active) begin
      r_next.util_lock = 1'b0;
    end

    // Main power loss while cut off
    if (r_reg.st == HPC_CUTOFF && !pwr_ok) begin
      r_next.pwr_hold = 1'b1;
    end else if (!son) begin
      r_next.pwr_hold = 1'b0;
    end

    case (r_reg.st)
      HPC_CUTOFF: begin
        if (both_on && !son && !r_reg.pwr_hold && !r_reg.util_lock) begin
          r_next.st = HPC_BB;
          ev[INT_REL] = 1'b1;
        end
      end
      HPC_BB: begin
        if (son && pwr_ok) begin
          r_next.st = HPC_RUN;
        end
      end
      HPC_RUN: begin
        if (!son || !pwr_ok) begin
          r_next.st = HPC_BRK_WAIT;
          r_next.brk_cnt = '0;
        end
      end
      HPC_BRK_WAIT: begin
        // Brake engages first, power holds for the delay
        if (r_reg.brk_cnt >= r_reg.brk_dly) begin
          r_next.st = HPC_BB;
        end else if (r_reg.ms_tick) begin
          r_next.brk_cnt = r_reg.brk_cnt + 1'b1;
        end
      end
      default: r_next.st = HPC_CUTOFF;
    endcase

    // Cutoff overrides every state
    if (!both_on && r_reg.st != HPC_CUTOFF) begin
      r_next.st = HPC_CUTOFF;
      ev[INT_CUT] = 1'b1;
      if (utility_active) begin
        r_next.util_lock = 1'b1;
      end
    end

    ev[INT_GLITCH] = |f_glitch;
    r_next.int_stat = r_next.int_stat | ev;
    r_next.irq = |(r_next.int_stat & r_next.int_mask);

    // Outputs follow the next state
    r_next.cut = (r_next.st == HPC_CUTOFF);
    r_next.pwr_en = (r_next.st == HPC_RUN) || (r_next.st == HPC_BRK_WAIT);
    r_next.rdy = !r_next.cut;
    r_next.brk_rel = (r_next.st == HPC_RUN);
    r_next.dyn_brk = r_next.cut && r_reg.dynbrk_set;

    // Register reads, data one cycle later
    r_next.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: begin
          r_next.rdata[CTRL_ALWAYS_BIT] = r_reg.always_set;
          r_next.rdata[CTRL_DYNBRK_BIT] = r_reg.dynbrk_set;
        end
        ADDR_BRK_DLY: r_next.rdata = r_reg.brk_dly;
        ADDR_MM_WIN: r_next.rdata = r_reg.mm_win;
        ADDR_STATUS: begin
          r_next.rdata = {1'b0, r_reg.pwr_hold, r_reg.util_lock,
                          r_reg.alarm, f_on, r_reg.st};
        end
        ADDR_INT_STAT: r_next.rdata[INT_W-1:0] = r_reg.int_stat;
        ADDR_INT_MASK: r_next.rdata[INT_W-1:0] = r_reg.int_mask;
        default: r_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg <= '0;
      r_reg.st <= HPC_CUTOFF;
      r_reg.cut <= 1'b1;
      r_reg.dyn_brk <= CTRL_DYNBRK_RST;
      r_reg.always_set <= CTRL_ALWAYS_RST;
      r_reg.dynbrk_set <= CTRL_DYNBRK_RST;
      r_reg.brk_dly <= BRK_DLY_RST;
      r_reg.mm_win <= MM_WIN_RST;
      r_reg.int_mask <= INT_MASK_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata = r_reg.rdata;
  assign power_stage_en = r_reg.pwr_en;
  assign servo_ready = r_reg.rdy;
  assign brake_release_out = r_reg.brk_rel;
  assign dyn_brake_out = r_reg.dyn_brk;
  assign hard_power_cutoff = r_reg.cut;
  assign input_mismatch_alarm = r_reg.alarm;
  assign utility_lock = r_reg.util_lock;
  assign irq = r_reg.irq;

  // ****************************************
  // Checks
  // ****************************************
  logic [CW-1:0] both_off_run;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      both_off_run <= '0;
    end else if (|f_sync) begin
      both_off_run <= '0;
    end else if (both_off_run != '1) begin
      both_off_run <= both_off_run + 1'b1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_cut_req;
    !(&f_on) && r_reg.st != HPC_CUTOFF;
  endsequence

  sequence s_release_ok;
    r_reg.st == HPC_CUTOFF && (&f_on) && !son && !r_reg.pwr_hold
      && !r_reg.util_lock;
  endsequence

  a_cut_entry: assert property (
    s_cut_req |=> hard_power_cutoff && !power_stage_en)
    else $error("Cutoff not entered after input OFF");

  a_cut_brake: assert property (
    s_cut_req |=> !brake_release_out)
    else $error("Brake release still high on cutoff entry");

  a_cut_time: assert property (
    both_off_run < CW'(CUTOFF_CYC) || !power_stage_en)
    else $error("Power still on 20 ms after both inputs OFF");

  a_release_bb: assert property (
    s_release_ok |=> r_reg.st == HPC_BB ##1 servo_ready)
    else $error("Cutoff not released to base block");

  a_son_hold: assert property (
    r_reg.st == HPC_CUTOFF && son |=> r_reg.st == HPC_CUTOFF)
    else $error("Cutoff left while servo-on active");

  a_pwr_hold: assert property (
    r_reg.pwr_hold && son |=> r_reg.st == HPC_CUTOFF)
    else $error("Cutoff left during main power hold");

  a_always_on: assert property (
    r_reg.always_set && r_reg.st == HPC_CUTOFF |=> hard_power_cutoff)
    else $error("Cutoff left with servo-on always active");

  a_alarm_set: assert property (
    $rose(input_mismatch_alarm) |-> $past(f_on[0] != f_on[1]))
    else $error("Mismatch alarm without channel mismatch");

  a_util_lock: assert property (
    r_reg.util_lock && r_reg.st == HPC_CUTOFF |=> r_reg.st == HPC_CUTOFF)
    else $error("Cutoff left while utility lock held");

  a_ready_off: assert property (
    hard_power_cutoff |-> !servo_ready && !power_stage_en)
    else $error("Servo ready while cut off");

  a_ready_back: assert property (
    $rose(servo_ready) |-> $past(&f_on) && !$past(son))
    else $error("Servo ready returned without release");

  a_dyn_brake: assert property (
    hard_power_cutoff && $past(r_reg.dynbrk_set) |-> dyn_brake_out)
    else $error("Dynamic brake not applied in cutoff");

endmodule : hpc_cutoff_ctrl

// ### src/hpc_off_filter.sv
`timescale 1ns/1ps
module hpc_off_filter #(
  parameter int IGN_CYC = 10000,
  parameter int CW = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Raw pin, high while ON
  input wire logic pin_on,
  // Filtered level and events
  output logic on_out,
  output logic on_sync,
  output logic glitch
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic on;
    logic [CW-1:0] cnt;
    logic glitch;
  } hpc_filt_t;

  hpc_filt_t r_reg;
  hpc_filt_t r_next;

  always_comb begin
    r_next = r_reg;
    r_next.s1 = pin_on;
    r_next.s2 = r_reg.s1;
    r_next.glitch = 1'b0;
    if (r_reg.s2) begin
      // Short OFF pulse never reached the threshold
      r_next.glitch = r_reg.on && (r_reg.cnt != '0);
      r_next.cnt = '0;
      r_next.on = 1'b1;
    end else if (r_reg.cnt >= CW'(IGN_CYC)) begin
      r_next.on = 1'b0;
    end else begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign on_out = r_reg.on;
  assign on_sync = r_reg.s2;
  assign glitch = r_reg.glitch;

endmodule : hpc_off_filter

// ### src/hpc_pkg.sv
package hpc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int OFF_IGNORE_US = 500;
  localparam int OFF_IGNORE_CYC = OFF_IGNORE_US * (CLK_HZ / 1_000_000);
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int CUTOFF_MAX_MS = 20;
  localparam int CUTOFF_MAX_CYC = CUTOFF_MAX_MS * MS_CYC;
  localparam int CW = 20;

  // ****************************************
  // Register port
  // ****************************************
  localparam int AW = 5;
  localparam int DW = 8;
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_BRK_DLY = 5'h04;
  localparam logic [4:0] ADDR_MM_WIN = 5'h08;
  localparam logic [4:0] ADDR_STATUS = 5'h0c;
  localparam logic [4:0] ADDR_INT_STAT = 5'h10;
  localparam logic [4:0] ADDR_INT_MASK = 5'h14;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int CTRL_ALWAYS_BIT = 0;
  localparam int CTRL_DYNBRK_BIT = 1;
  localparam int CTRL_ALM_CLR_BIT = 2;
  localparam logic CTRL_ALWAYS_RST = 1'b0;
  localparam logic CTRL_DYNBRK_RST = 1'b1;
  localparam logic [7:0] BRK_DLY_RST = 8'h0a;
  localparam logic [7:0] MM_WIN_RST = 8'h0a;
  localparam int INT_W = 4;
  localparam int INT_CUT = 0;
  localparam int INT_REL = 1;
  localparam int INT_ALM = 2;
  localparam int INT_GLITCH = 3;
  localparam logic [3:0] INT_MASK_RST = 4'h0;

  typedef enum logic [1:0] {
    HPC_CUTOFF,
    HPC_BB,
    HPC_RUN,
    HPC_BRK_WAIT
  } hpc_state_t;

endpackage : hpc_pkg

// ### test/hpc_cutoff_ctrl_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  bad_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
`define WAITC(c, n) begin k = 0; while (!(c) && k < (n)) begin \
  @(posedge clk); #1; k++; end end
module hpc_cutoff_ctrl_bench;
  import hpc_pkg::*;
  localparam int IGN = 8;
  localparam int MSC = 10;
  localparam int CUTC = 100;
  logic clk, sys_rst, servo_on_cmd, main_power_ok, utility_active;
  logic reg_wr, reg_rd, open_a, open_b, pin_a, pin_b;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, d;
  logic power_stage_en, servo_ready, brake_release_out, dyn_brake_out;
  logic hard_power_cutoff, input_mismatch_alarm, utility_lock, irq;
  int bad_count, n_tests, k, cyc, len;
  logic [4:0] ra [5] = '{5'h00, 5'h04, 5'h08, 5'h14, 5'h1c};
  logic [7:0] re [5] = '{8'h02, 8'h0a, 8'h0a, 8'h00, 8'h00};
  hpc_safety_unit hpc_safety_unit_inst (.clk(clk), .open_a(open_a),
    .open_b(open_b), .safety_cutoff_in_a(pin_a),
    .safety_cutoff_in_b(pin_b));
  hpc_cutoff_ctrl #(.IGN_CYC(IGN), .MS_CYC_P(MSC), .CUTOFF_CYC(CUTC))
    hpc_cutoff_ctrl_inst (.clk(clk), .sys_rst(sys_rst),
    .safety_cutoff_in_a(pin_a), .safety_cutoff_in_b(pin_b),
    .servo_on_cmd(servo_on_cmd), .main_power_ok(main_power_ok),
    .utility_active(utility_active), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .power_stage_en(power_stage_en),
    .servo_ready(servo_ready), .brake_release_out(brake_release_out),
    .dyn_brake_out(dyn_brake_out), .hard_power_cutoff(hard_power_cutoff),
    .input_mismatch_alarm(input_mismatch_alarm),
    .utility_lock(utility_lock), .irq(irq));
  // ****************************************
  // Clock, timeout and tasks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc_n
  function automatic logic [7:0] exp_status(input logic [1:0] st,
    input logic a_on, input logic b_on, input logic alm, input logic ul);
    return {2'h0, ul, alm, b_on, a_on, st};
  endfunction : exp_status
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {servo_on_cmd, utility_active, reg_wr, reg_rd} = 4'h0;
    {reg_addr, reg_wdata, cyc, bad_count, n_tests} = '0;
    {main_power_ok, open_a, open_b, sys_rst} = 4'hf;
    len = $urandom(32'h2302);
    cyc_n(5);
    sys_rst <= 1'b0;
    cyc_n(1);
    `CHK("cutoff_rst", 1'b1, hard_power_cutoff)
    for (int i = 0; i < 5; i++) begin
      rd(ra[i]);
      `CHK("reg_rst", re[i], d)
    end
    wr(ADDR_INT_MASK, 8'h0f);
    wr(ADDR_INT_STAT, 8'h0f);
    {open_a, open_b} <= 2'b00;
    `WAITC(servo_ready, 30)
    `CHK("ready_bb", 1'b1, servo_ready)
    `CHK("cutoff_bb", 1'b0, hard_power_cutoff)
    rd(ADDR_INT_STAT);
    `CHK("int_rel", 1'b1, d[INT_REL])
    `CHK("irq_on", 1'b1, irq)
    wr(ADDR_INT_STAT, 8'hff);
    cyc_n(2);
    `CHK("irq_clr", 1'b0, irq)
    servo_on_cmd <= 1'b1;
    `WAITC(power_stage_en, 20)
    `CHK("brake_run", 1'b1, brake_release_out)
    for (int i = 0; i < 3; i++) begin
      len = (i == 0) ? IGN : 1 + $urandom % IGN;
      open_a <= 1'b1;
      cyc_n(len);
      open_a <= 1'b0;
      cyc_n(20);
      `CHK("glitch_cut", 1'b0, hard_power_cutoff)
    end
    rd(ADDR_INT_STAT);
    `CHK("int_glitch", 1'b1, d[INT_GLITCH])
    open_a <= 1'b1;
    `WAITC(hard_power_cutoff, IGN + 6)
    `CHK("cut_one", 1'b1, hard_power_cutoff)
    `CHK("pwr_cut", 1'b0, power_stage_en)
    `CHK("brake_cut", 1'b0, brake_release_out)
    `CHK("dyn_on", 1'b1, dyn_brake_out)
    `CHK("ready_cut", 1'b0, servo_ready)
    rd(ADDR_STATUS);
    `CHK("status_cut", exp_status(2'h0, 1'b0, 1'b1, 1'b0, 1'b0), d)
    `WAITC(input_mismatch_alarm, 14 * MSC)
    `CHK("alarm", 1'b1, input_mismatch_alarm)
    wr(ADDR_INT_MASK, 8'h00);
    cyc_n(2);
    `CHK("irq_mask", 1'b0, irq)
    wr(ADDR_INT_MASK, 8'h0f);
    cyc_n(2);
    `CHK("irq_unmask", 1'b1, irq)
    open_a <= 1'b0;
    cyc_n(40);
    `CHK("hold_son", 1'b1, hard_power_cutoff)
    `CHK("ready_son", 1'b0, servo_ready)
    servo_on_cmd <= 1'b0;
    `WAITC(servo_ready, 30)
    `CHK("rel_son", 1'b0, hard_power_cutoff)
    `CHK("alarm_sticky", 1'b1, input_mismatch_alarm)
    wr(ADDR_CTRL, 8'h06);
    cyc_n(2);
    `CHK("alarm_clr", 1'b0, input_mismatch_alarm)
    // Servo-on dropped before both channels open
    servo_on_cmd <= 1'b1;
    `WAITC(power_stage_en, 20)
    servo_on_cmd <= 1'b0;
    cyc_n(30);
    `CHK("brk_wait_pwr", 1'b1, power_stage_en)
    `CHK("brk_wait_brk", 1'b0, brake_release_out)
    `WAITC(!power_stage_en, 15 * MSC)
    wr(ADDR_CTRL, 8'h00);
    {open_a, open_b} <= 2'b11;
    `WAITC(hard_power_cutoff, CUTC)
    `CHK("cut_both", 1'b1, hard_power_cutoff)
    `CHK("pwr_both", 1'b0, power_stage_en)
    `CHK("dyn_off", 1'b0, dyn_brake_out)
    main_power_ok <= 1'b0;
    servo_on_cmd <= 1'b1;
    cyc_n(10);
    {open_a, open_b} <= 2'b00;
    main_power_ok <= 1'b1;
    cyc_n(40);
    `CHK("pwr_hold", 1'b1, hard_power_cutoff)
    servo_on_cmd <= 1'b0;
    `WAITC(servo_ready, 30)
    `CHK("pwr_rel", 1'b0, hard_power_cutoff)
    utility_active <= 1'b1;
    open_b <= 1'b1;
    `WAITC(hard_power_cutoff, IGN + 6)
    `CHK("util_lock", 1'b1, utility_lock)
    rd(ADDR_STATUS);
    `CHK("status_util", exp_status(2'h0, 1'b1, 1'b0, 1'b0, 1'b1), d)
    open_b <= 1'b0;
    cyc_n(40);
    `CHK("util_hold", 1'b1, hard_power_cutoff)
    utility_active <= 1'b0;
    `WAITC(!hard_power_cutoff, 30)
    `CHK("util_rel", 1'b0, hard_power_cutoff)
    wr(ADDR_CTRL, 8'h01);
    open_a <= 1'b1;
    `WAITC(hard_power_cutoff, IGN + 6)
    open_a <= 1'b0;
    cyc_n(60);
    `CHK("always_hold", 1'b1, hard_power_cutoff)
    wr(ADDR_CTRL, 8'h00);
    `WAITC(!hard_power_cutoff, 30)
    `CHK("always_rel", 1'b0, hard_power_cutoff)
    sys_rst <= 1'b1;
    cyc_n(2);
    `CHK("cutoff_rst2", 1'b1, hard_power_cutoff)
    sys_rst <= 1'b0;
    cyc_n(2);
    `WAITC(servo_ready, 30)
    `CHK("ready_rst2", 1'b1, servo_ready)
    tally_and_finish();
  end
endmodule : hpc_cutoff_ctrl_bench

// ### test/hpc_safety_unit.sv
`timescale 1ns/1ps
// ****************************************
// Two-channel safety unit model
// ****************************************
module hpc_safety_unit (
  // Clock
  input wire logic clk,
  // Contact open requests
  input wire logic open_a,
  input wire logic open_b,
  // Safety pins, high while ON
  output logic safety_cutoff_in_a,
  output logic safety_cutoff_in_b
);
  // Each channel switches on its own, so one may open alone
  initial begin
    safety_cutoff_in_a = 1'b0;
    safety_cutoff_in_b = 1'b0;
  end
  always @(posedge clk) begin
    safety_cutoff_in_a <= !open_a;
    safety_cutoff_in_b <= !open_b;
  end
endmodule : hpc_safety_unit
